// [src/peripheral_irq_enable_bank.v]
/*
  Peripheral interrupt enable bank: core interrupt control, first peripheral
  enable register, pin-change detection on the second I/O port, a free
  timer-zero counter, sticky event status with mask, and an AXI4-Lite slave.
  Assumes peripheral event pulses come from logic on I_CLK, port pins are
  asynchronous, and a single master with one write and one read in flight.
*/
// The address map and register access over AXI4-Lite were decided locally.
`include "irq_bank_defines.vh"
`default_nettype none

// How it works
// - Any stable change on a port pin sets the port-change flag until cleared.
// - Port-change interrupt also needs a changed pin whose per-pin enable is set.
// - Timer-zero rollover sets its flag, which stays until software clears it.
// - Reset leaves the timer-zero count alone; software loads it first.
// - Peripheral sources interrupt only while the peripheral gate bit is set.
// - Enable register bit 7 is unimplemented and reads zero.
// - Enable bit 6 gates the converter interrupt.
// - Enable bit 5 gates the serial receive interrupt.
// - Enable bit 4 gates the serial transmit interrupt.
// - Enable bit 3 gates the synchronous serial interrupt.
// - Enable bit 2 gates the capture/compare one interrupt.
// - Enable bit 1 gates the timer-two period match interrupt.
// - Enable bit 0 gates the timer-one overflow interrupt.
// - Peripheral flags set on their event whatever the enables hold.

module peripheral_irq_enable_bank #(
  parameter PORT_WIDTH = 8,
  parameter SRC_COUNT  = 7
) (
  input  wire                  I_CLK,
  input  wire                  I_RST_N,
  input  wire                  I_CE,
  input  wire [PORT_WIDTH-1:0] I_PORT_PIN,
  input  wire [SRC_COUNT-1:0]  I_PERIPH_EVT,
  input  wire                  I_TIMER_ZERO_TICK,
  input  wire [7:0]            I_AWADDR,
  input  wire                  I_AWVALID,
  output reg                   O_AWREADY,
  input  wire [31:0]           I_WDATA,
  input  wire [3:0]            I_WSTRB,
  input  wire                  I_WVALID,
  output reg                   O_WREADY,
  output reg  [1:0]            O_BRESP,
  output reg                   O_BVALID,
  input  wire                  I_BREADY,
  input  wire [7:0]            I_ARADDR,
  input  wire                  I_ARVALID,
  output reg                   O_ARREADY,
  output reg  [31:0]           O_RDATA,
  output reg  [1:0]            O_RRESP,
  output reg                   O_RVALID,
  input  wire                  I_RREADY,
  output reg                   O_IRQ,
  output reg                   O_PERIPH_REQ
);

  // Software registers
  reg  [7:0]            core_ctrl_r;
  reg  [6:0]            periph_en_r;
  reg  [PORT_WIDTH-1:0] pin_mask_r;
  reg  [`ST_WIDTH-1:0]  status_r;
  reg  [`ST_WIDTH-1:0]  status_nxt;
  reg  [`ST_WIDTH-1:0]  irq_mask_r;
  reg  [7:0]            timer_zero_r;

  // Port sampling
  reg  [PORT_WIDTH-1:0] pin_s1_r;
  reg  [PORT_WIDTH-1:0] pin_s2_r;
  reg  [PORT_WIDTH-1:0] pin_s3_r;
  reg  [PORT_WIDTH-1:0] pin_last_r;
  reg  [PORT_WIDTH-1:0] pin_changed_r;
  reg                   primed_r;
  reg  [1:0]            prime_cnt_r;
  wire [PORT_WIDTH-1:0] pin_edge;

  // Bus capture
  reg  [7:0]            aw_addr_r;
  reg                   aw_held_r;
  reg  [31:0]           w_data_r;
  reg  [3:0]            w_strb_r;
  reg                   w_held_r;

  wire                  aw_fire;
  wire                  w_fire;
  wire                  ar_fire;
  wire                  do_write;
  wire [7:0]            wr_lane0;
  wire [7:0]            wr_lane1;
  wire                  lane0_on;
  wire                  lane1_on;
  wire                  wr_core;
  wire                  wr_pe;
  wire                  wr_pinm;
  wire                  wr_stat;
  wire                  wr_mask;
  wire                  wr_tmr;
  wire                  wr_hit;

  wire                  t0_roll;
  wire                  port_evt;
  wire                  global_on;
  wire                  periph_hit;
  wire                  port_hit;
  wire                  t0_hit;
  wire [SRC_COUNT-1:0]  periph_live;
  wire [`ST_WIDTH-1:0]  qual;

  reg  [31:0]           rd_word;
  reg                   rd_hit;

  assign aw_fire  = I_AWVALID & O_AWREADY;
  assign w_fire   = I_WVALID & O_WREADY;
  assign ar_fire  = I_ARVALID & O_ARREADY;
  assign do_write = aw_held_r & w_held_r & ~O_BVALID;

  assign wr_lane0 = w_data_r[7:0];
  assign wr_lane1 = w_data_r[15:8];
  assign lane0_on = w_strb_r[0];
  assign lane1_on = w_strb_r[1];

  assign wr_core = do_write & (aw_addr_r == `OFS_CORE_CTRL);
  assign wr_pe   = do_write & (aw_addr_r == `OFS_PERIPH_EN_ONE);
  assign wr_pinm = do_write & (aw_addr_r == `OFS_PIN_CHANGE_MASK);
  assign wr_stat = do_write & (aw_addr_r == `OFS_IRQ_STATUS);
  assign wr_mask = do_write & (aw_addr_r == `OFS_IRQ_MASK);
  assign wr_tmr  = do_write & (aw_addr_r == `OFS_TIMER_ZERO);
  assign wr_hit  = wr_core | wr_pe | wr_pinm | wr_stat | wr_mask | wr_tmr |
                   (aw_addr_r == `OFS_PORT_LEVEL);

  // Three-stage pin synchroniser; only stages two and three are compared
  always @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      pin_s1_r <= {PORT_WIDTH{1'b0}};
      pin_s2_r <= {PORT_WIDTH{1'b0}};
      pin_s3_r <= {PORT_WIDTH{1'b0}};
      primed_r <= 1'b0;
      prime_cnt_r <= 2'h0;
    end else if (I_CE) begin
      pin_s1_r <= I_PORT_PIN;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
      // Stage three holds reset zeros at first; a pin idling high must not count
      if (prime_cnt_r != `SYNC_PRIME_COUNT) begin
        prime_cnt_r <= prime_cnt_r + 2'h1;
      end
      primed_r <= (prime_cnt_r == `SYNC_PRIME_COUNT);
    end
  end

  // Per-pin change detection; the first four samples after reset only load the reference
  genvar gi;
  generate
    for (gi = 0; gi < PORT_WIDTH; gi = gi + 1) begin : g_pin
      assign pin_edge[gi] = primed_r & (pin_s2_r[gi] == pin_s3_r[gi]) &
                            (pin_s3_r[gi] != pin_last_r[gi]);

      always @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
          pin_last_r[gi]    <= 1'b0;
          pin_changed_r[gi] <= 1'b0;
        end else if (I_CE) begin
          if (!primed_r || (pin_s2_r[gi] == pin_s3_r[gi])) begin
            pin_last_r[gi] <= pin_s3_r[gi];
          end
          // Set beats the clear that comes with the flag's write-one
          if (pin_edge[gi]) begin
            pin_changed_r[gi] <= 1'b1;
          end else if (wr_stat && lane1_on &&
                       wr_lane1[`ST_PORT_CHANGE-8]) begin
            pin_changed_r[gi] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  assign port_evt = |pin_edge;

  // Timer-zero counter has no reset so that its count survives it
  assign t0_roll = I_TIMER_ZERO_TICK & (timer_zero_r == `TIMER_ZERO_TOP);

  always @(posedge I_CLK) begin
    if (I_CE) begin
      if (wr_tmr && lane0_on) begin
        timer_zero_r <= wr_lane0;
      end else if (I_TIMER_ZERO_TICK) begin
        timer_zero_r <= timer_zero_r + 8'h01;
      end
    end
  end

  // Sticky status: hardware set wins over write-one-to-clear
  always @* begin
    status_nxt = status_r;
    if (wr_stat && lane0_on) begin
      status_nxt[7:0] = status_nxt[7:0] & ~wr_lane0;
    end
    if (wr_stat && lane1_on) begin
      status_nxt[`ST_WIDTH-1:8] = status_nxt[`ST_WIDTH-1:8] &
                                  ~wr_lane1[`ST_WIDTH-9:0];
    end
    status_nxt[SRC_COUNT-1:0] = status_nxt[SRC_COUNT-1:0] | I_PERIPH_EVT;
    if (t0_roll) begin
      status_nxt[`ST_TIMER_ZERO] = 1'b1;
    end
    if (port_evt) begin
      status_nxt[`ST_PORT_CHANGE] = 1'b1;
    end
  end

  // Configuration registers
  always @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      core_ctrl_r <= `RST_CORE_CTRL;
      periph_en_r <= 7'h00;
      pin_mask_r  <= {PORT_WIDTH{1'b0}};
      status_r    <= `RST_IRQ_STATUS;
      irq_mask_r  <= `RST_IRQ_MASK;
    end else if (I_CE) begin
      status_r <= status_nxt;
      if (wr_core && lane0_on) begin
        core_ctrl_r <= wr_lane0 & `CC_WRITE_MASK;
      end
      if (wr_pe && lane0_on) begin
        periph_en_r <= wr_lane0[6:0];
      end
      if (wr_pinm && lane0_on) begin
        pin_mask_r <= wr_lane0[PORT_WIDTH-1:0];
      end
      if (wr_mask && lane0_on) begin
        irq_mask_r[7:0] <= wr_lane0;
      end
      if (wr_mask && lane1_on) begin
        irq_mask_r[`ST_WIDTH-1:8] <= wr_lane1[`ST_WIDTH-9:0];
      end
    end
  end

  // Interrupt qualification
  assign global_on   = core_ctrl_r[`CC_GLOBAL_GATE];
  // One enable per source: bit 6 converter, 5 rx, 4 tx, 3 sync serial,
  // 2 capcomp one, 1 timer-two match, 0 timer-one overflow
  assign periph_live = status_r[SRC_COUNT-1:0] & periph_en_r;
  assign periph_hit  = global_on & core_ctrl_r[`CC_PERIPH_GATE] & (|periph_live);
  // A change on a pin whose enable is clear still flags, and interrupts only once that enable is set
  assign port_hit    = global_on & core_ctrl_r[`CC_PORT_CHANGE_EN] &
                       status_r[`ST_PORT_CHANGE] & (|(pin_changed_r & pin_mask_r));
  assign t0_hit      = global_on & core_ctrl_r[`CC_TIMER_ZERO_EN] &
                       status_r[`ST_TIMER_ZERO];

  assign qual = {port_hit, t0_hit, 1'b0,
                 {SRC_COUNT{global_on & core_ctrl_r[`CC_PERIPH_GATE]}} & periph_live};

  always @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_IRQ        <= 1'b0;
      O_PERIPH_REQ <= 1'b0;
    end else if (I_CE) begin
      O_IRQ        <= |(qual & irq_mask_r);
      O_PERIPH_REQ <= periph_hit;
    end
  end

  // Read mux
  always @* begin
    rd_word = 32'h0000_0000;
    rd_hit  = 1'b1;
    case ({I_ARADDR[7:2], 2'b00})
      `OFS_CORE_CTRL: begin
        rd_word[7:0] = core_ctrl_r;
        rd_word[`CC_TIMER_ZERO_FLAG]  = status_r[`ST_TIMER_ZERO];
        rd_word[`CC_PORT_CHANGE_FLAG] = status_r[`ST_PORT_CHANGE];
      end
      `OFS_PERIPH_EN_ONE: begin
        rd_word[7:0] = {1'b0, periph_en_r} & `PE_IMPL_MASK;
      end
      `OFS_PIN_CHANGE_MASK: begin
        rd_word[PORT_WIDTH-1:0] = pin_mask_r;
      end
      `OFS_IRQ_STATUS: begin
        rd_word[`ST_WIDTH-1:0] = status_r;
      end
      `OFS_IRQ_MASK: begin
        rd_word[`ST_WIDTH-1:0] = irq_mask_r;
      end
      `OFS_TIMER_ZERO: begin
        rd_word[7:0] = timer_zero_r;
      end
      `OFS_PORT_LEVEL: begin
        rd_word[PORT_WIDTH-1:0] = pin_last_r;
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  // Write channels are captured independently and answered once both are held
  always @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_AWREADY <= 1'b0;
      O_WREADY  <= 1'b0;
      O_BVALID  <= 1'b0;
      O_BRESP   <= `RESP_OKAY;
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r  <= 32'h0000_0000;
      w_strb_r  <= 4'h0;
    end else if (I_CE) begin
      if (aw_fire) begin
        aw_addr_r <= {I_AWADDR[7:2], 2'b00};
        aw_held_r <= 1'b1;
        O_AWREADY <= 1'b0;
      end else if (!aw_held_r && !O_BVALID) begin
        O_AWREADY <= 1'b1;
      end
      if (w_fire) begin
        w_data_r <= I_WDATA;
        w_strb_r <= I_WSTRB;
        w_held_r <= 1'b1;
        O_WREADY <= 1'b0;
      end else if (!w_held_r && !O_BVALID) begin
        O_WREADY <= 1'b1;
      end
      if (do_write) begin
        O_BVALID  <= 1'b1;
        O_BRESP   <= wr_hit ? `RESP_OKAY : `RESP_DECERR;
        aw_held_r <= 1'b0;
        w_held_r  <= 1'b0;
      end else if (O_BVALID && I_BREADY) begin
        O_BVALID <= 1'b0;
      end
    end
  end

  // Read channel: one outstanding read, data captured at the address handshake
  always @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_ARREADY <= 1'b0;
      O_RVALID  <= 1'b0;
      O_RDATA   <= 32'h0000_0000;
      O_RRESP   <= `RESP_OKAY;
    end else if (I_CE) begin
      if (ar_fire) begin
        O_ARREADY <= 1'b0;
        O_RVALID  <= 1'b1;
        O_RDATA   <= rd_word;
        O_RRESP   <= rd_hit ? `RESP_OKAY : `RESP_DECERR;
      end else if (O_RVALID && I_RREADY) begin
        O_RVALID <= 1'b0;
      end else if (!O_RVALID) begin
        O_ARREADY <= 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// [src/irq_bank_defines.vh]
/*
  Register map, field positions, reset values and response codes for the
  peripheral interrupt enable bank.
  Assumes a 32-bit AXI4-Lite register bus with one aligned word per register.
*/
`ifndef IRQ_BANK_DEFINES_VH
`define IRQ_BANK_DEFINES_VH

// Register byte offsets
`define OFS_CORE_CTRL        8'h00
`define OFS_PERIPH_EN_ONE    8'h04
`define OFS_PIN_CHANGE_MASK  8'h08
`define OFS_IRQ_STATUS       8'h0C
`define OFS_IRQ_MASK         8'h10
`define OFS_TIMER_ZERO       8'h14
`define OFS_PORT_LEVEL       8'h18

// core_irq_control fields
`define CC_GLOBAL_GATE       7
`define CC_PERIPH_GATE       6
`define CC_PORT_CHANGE_EN    3
`define CC_TIMER_ZERO_EN     2
`define CC_TIMER_ZERO_FLAG   1
`define CC_PORT_CHANGE_FLAG  0
`define CC_WRITE_MASK        8'hCC

// peripheral_irq_enable_one: bit 7 unimplemented
`define PE_IMPL_MASK         8'h7F

// Status and mask layout: bits 6..0 peripheral sources
`define ST_TIMER_ZERO        8
`define ST_PORT_CHANGE       9
`define ST_WIDTH             10

// Reset values
`define RST_CORE_CTRL        8'h00
`define RST_PERIPH_EN_ONE    8'h00
`define RST_PIN_CHANGE_MASK  8'h00
`define RST_IRQ_STATUS       10'h000
`define RST_IRQ_MASK         10'h3FF

// Enabled edges before stage three holds a real sample; the pin reference loads it one edge later
`define SYNC_PRIME_COUNT     2'h3

// Timer zero rolls over from this count
`define TIMER_ZERO_TOP       8'hFF

// AXI responses
`define RESP_OKAY            2'h0
`define RESP_DECERR          2'h3

`endif

// [verification/irq_bank_monitor.sv]
/*
  Port checker for the interrupt enable bank.
  Assumes I_CE stays high, so each handshake step takes one clock.
*/
`default_nettype none
module irq_bank_monitor #(
  parameter SRC_COUNT = 7
) (
  input wire logic                 I_CLK,
  input wire logic                 I_RST_N,
  input wire logic [SRC_COUNT-1:0] I_PERIPH_EVT,
  input wire logic                 I_AWVALID,
  input wire logic                 O_AWREADY,
  input wire logic                 I_WVALID,
  input wire logic                 O_WREADY,
  input wire logic                 O_BVALID,
  input wire logic                 I_BREADY,
  input wire logic [7:0]           I_ARADDR,
  input wire logic                 I_ARVALID,
  input wire logic                 O_ARREADY,
  input wire logic [31:0]          O_RDATA,
  input wire logic [1:0]           O_RRESP,
  input wire logic                 O_RVALID,
  input wire logic                 I_RREADY,
  input wire logic                 O_IRQ,
  input wire logic                 O_PERIPH_REQ
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (!I_RST_N);
  sequence s_wr_taken;
    I_AWVALID && O_AWREADY && I_WVALID && O_WREADY;
  endsequence
  sequence s_wr_answer;
    !O_AWREADY && !O_WREADY ##1 O_BVALID;
  endsequence
  property p_wr_walk;
    s_wr_taken |=> s_wr_answer;
  endproperty
  a_wr_walk: assert property (p_wr_walk) else $error("write answer out of step");
  property p_b_done;
    O_BVALID && I_BREADY |=> !O_BVALID ##1 O_AWREADY && O_WREADY;
  endproperty
  a_b_done: assert property (p_b_done) else $error("write channel not reopened");
  property p_rd_walk;
    I_ARVALID && O_ARREADY |=> O_RVALID && !O_ARREADY;
  endproperty
  a_rd_walk: assert property (p_rd_walk) else $error("read answer out of step");
  property p_r_done;
    O_RVALID && I_RREADY |=> !O_RVALID ##1 O_ARREADY;
  endproperty
  a_r_done: assert property (p_r_done) else $error("read channel not reopened");
  property p_bit7_zero;
    I_ARVALID && O_ARREADY && I_ARADDR[7:2] == 6'h01 |=> O_RDATA[7] == 1'b0;
  endproperty
  a_bit7_zero: assert property (p_bit7_zero) else $error("enable bit 7 read as one");
  property p_decerr;
    I_ARVALID && O_ARREADY && I_ARADDR > 8'h1B |=> O_RRESP == 2'h3 && O_RDATA == 32'h0;
  endproperty
  a_decerr: assert property (p_decerr) else $error("unmapped read answered");
  // Request may only rise from an event or a register write
  property p_req_cause;
    $rose(O_PERIPH_REQ) |-> ($past(I_PERIPH_EVT, 2) != {SRC_COUNT{1'b0}}) ||
                            $past(O_BVALID) || $past(O_BVALID, 2);
  endproperty
  a_req_cause: assert property (p_req_cause) else $error("request rose uncaused");
  property p_irq_sticky;
    $fell(O_IRQ) |-> $past(O_BVALID) || $past(O_BVALID, 2);
  endproperty
  a_irq_sticky: assert property (p_irq_sticky) else $error("irq dropped untouched");
endmodule

bind peripheral_irq_enable_bank irq_bank_monitor #(.SRC_COUNT(SRC_COUNT)) chk (
  .I_CLK(I_CLK), .I_RST_N(I_RST_N), .I_PERIPH_EVT(I_PERIPH_EVT), .I_AWVALID(I_AWVALID),
  .O_AWREADY(O_AWREADY), .I_WVALID(I_WVALID), .O_WREADY(O_WREADY), .O_BVALID(O_BVALID),
  .I_BREADY(I_BREADY), .I_ARADDR(I_ARADDR), .I_ARVALID(I_ARVALID), .O_ARREADY(O_ARREADY),
  .O_RDATA(O_RDATA), .O_RRESP(O_RRESP), .O_RVALID(O_RVALID), .I_RREADY(I_RREADY),
  .O_IRQ(O_IRQ), .O_PERIPH_REQ(O_PERIPH_REQ));
`default_nettype wire

// [verification/core_model.sv]
/*
  Processor core stand-in: samples the request lines each clock.
  Assumes the requests are levels on the bank's clock.
*/
`default_nettype none
module core_model (
  input  wire logic i_clk,
  input  wire logic i_irq,
  input  wire logic i_req,
  output var  logic o_seen_irq,
  output var  logic o_seen_req
);
  timeunit 1ns;
  timeprecision 1ps;
  // A polling core sees levels one clock late, so checks allow for it
  always @(posedge i_clk) begin
    o_seen_irq <= i_irq;
    o_seen_req <= i_req;
  end
endmodule
`default_nettype wire

// [verification/tb_top.sv]
/*
  Self-checking bench for the interrupt enable bank over AXI4-Lite.
  Assumes the register map of the defines header; I_CE held high.
*/
`include "irq_bank_defines.vh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 0, rst_n = 0, tick = 0, awv = 0, wv = 0, arv = 0, bready = 0, rready = 0;
  logic [7:0]  pin = 8'h00, awaddr = 8'h00, araddr = 8'h00;
  logic [6:0]  evt = 7'h00;
  logic [31:0] wdata = 32'h0, r;
  wire  [31:0] rdata;
  wire  [1:0]  bresp, rresp;
  wire         awrdy, wrdy, bvalid, arrdy, rvalid, irq, req, seen_irq, seen_req;
  logic [33:0] notes[$];
  int          err_count = 0, samples_checked = 0;
  always #2 clk = ~clk;
  peripheral_irq_enable_bank uut (.I_CLK(clk), .I_RST_N(rst_n), .I_CE(1'b1),
    .I_PORT_PIN(pin), .I_PERIPH_EVT(evt), .I_TIMER_ZERO_TICK(tick), .I_AWADDR(awaddr),
    .I_AWVALID(awv), .O_AWREADY(awrdy), .I_WDATA(wdata), .I_WSTRB(4'hF), .I_WVALID(wv),
    .O_WREADY(wrdy), .O_BRESP(bresp), .O_BVALID(bvalid), .I_BREADY(bready),
    .I_ARADDR(araddr), .I_ARVALID(arv), .O_ARREADY(arrdy), .O_RDATA(rdata),
    .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready), .O_IRQ(irq), .O_PERIPH_REQ(req));
  core_model core (.i_clk(clk), .i_irq(irq), .i_req(req), .o_seen_irq(seen_irq),
    .o_seen_req(seen_req));
  task automatic check(input logic [33:0] seen, exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out;
    $display("errors %0d checks %0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] eb = `RESP_OKAY);
    bit ap = 1, wp = 1;
    @(posedge clk);
    notes.push_back({32'h0, eb});
    awaddr <= a; wdata <= d; awv <= 1; wv <= 1; bready <= 1;
    while (ap || wp) begin
      @(posedge clk);
      if (ap && awrdy) begin ap = 0; awv <= 0; end
      if (wp && wrdy) begin wp = 0; wv <= 0; end
    end
    do @(posedge clk); while (!bvalid);
    bready <= 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    @(posedge clk);
    notes.push_back(e); araddr <= a; arv <= 1; rready <= 1;
    do @(posedge clk); while (!arrdy);
    arv <= 0;
    do @(posedge clk); while (!rvalid);
    rready <= 0;
  endtask
  task automatic pulse(input logic [6:0] e, input logic t);
    @(posedge clk);
    evt <= e; tick <= t;
    @(posedge clk);
    evt <= 7'h00; tick <= 0;
  endtask
  // Read results are paired with the oldest note as they appear
  always @(posedge clk) if (rvalid && rready) check({rresp, rdata}, notes.pop_front(), "read");
  always @(posedge clk) if (bvalid && bready) check({32'h0, bresp}, notes.pop_front(), "bresp");
  initial begin
    #40000;
    err_count++;
    close_out;
  end
  initial begin
    r = $urandom(7);
    repeat (12) @(posedge clk);
    rst_n <= 1;
    repeat (2) @(posedge clk);
    rd(`OFS_PERIPH_EN_ONE, 34'h0);
    rd(`OFS_IRQ_MASK, 34'h3FF);
    wr(`OFS_TIMER_ZERO, 32'hFE);
    pulse(7'h00, 1);
    pulse(7'h00, 1);
    rd(`OFS_IRQ_STATUS, 34'h100);
    rd(`OFS_TIMER_ZERO, 34'h0);
    wr(`OFS_TIMER_ZERO, 32'h5A);
    wr(`OFS_IRQ_STATUS, 32'h100);
    rd(`OFS_IRQ_STATUS, 34'h0);
    @(posedge clk) rst_n <= 0;
    repeat (3) @(posedge clk);
    rst_n <= 1;
    repeat (2) @(posedge clk);
    rd(`OFS_TIMER_ZERO, 34'h5A);
    r = ($urandom & 32'hFF) | 32'h80;
    wr(`OFS_PERIPH_EN_ONE, r);
    rd(`OFS_PERIPH_EN_ONE, {27'h0, r[6:0]});
    for (int i = 0; i < 7; i++) begin
      wr(`OFS_CORE_CTRL, 32'h80);
      wr(`OFS_PERIPH_EN_ONE, 32'h1 << i);
      pulse(7'h01 << i, 0);
      repeat (3) @(posedge clk);
      check({seen_irq, seen_req}, 2'b00, "gated request");
      rd(`OFS_IRQ_STATUS, 34'h1 << i);
      wr(`OFS_CORE_CTRL, 32'hC0);
      repeat (3) @(posedge clk);
      check({seen_irq, seen_req}, 2'b11, "request");
      wr(`OFS_PERIPH_EN_ONE, ~(32'h1 << i) & 32'h7F);
      repeat (3) @(posedge clk);
      check(seen_req, 1'b0, "other enables");
      wr(`OFS_IRQ_STATUS, 32'h7F);
    end
    wr(`OFS_CORE_CTRL, 32'h88);
    @(posedge clk) pin <= 8'h01;
    repeat (8) @(posedge clk);
    rd(`OFS_IRQ_STATUS, 34'h200);
    check(seen_irq, 1'b0, "unmasked pin irq");
    wr(`OFS_PIN_CHANGE_MASK, 32'h01);
    repeat (3) @(posedge clk);
    check(seen_irq, 1'b1, "pin irq");
    wr(`OFS_IRQ_MASK, 32'h1FF);
    repeat (3) @(posedge clk);
    check(seen_irq, 1'b0, "masked irq");
    wr(`OFS_IRQ_MASK, 32'h3FF);
    wr(`OFS_IRQ_STATUS, 32'h200);
    repeat (3) @(posedge clk);
    check(seen_irq, 1'b0, "cleared irq");
    rd(`OFS_IRQ_STATUS, 34'h0);
    wr(8'h40, 32'hFFFF, `RESP_DECERR);
    rd(8'h40, {2'h3, 32'h0});
    close_out;
  end
endmodule
`default_nettype wire
